// ### verilog/pcbf_pkg.sv
// Constants and state types of the bridge function configuration header
package pcbf_pkg;

    // ==========================================================
    // Register byte offsets in configuration space
    localparam logic [11:0] PCBF_ID_OFS        = 12'h100;
    localparam logic [11:0] PCBF_CMDSTAT_OFS   = 12'h104;
    localparam logic [11:0] PCBF_REVCLASS_OFS  = 12'h108;
    localparam logic [11:0] PCBF_HDRTYPE_OFS   = 12'h10C;

    // ==========================================================
    // Command half-word field positions and reset value
    localparam int          PCBF_CMD_MEM_BIT   = 1;
    localparam int          PCBF_CMD_PAR_BIT   = 6;
    localparam int          PCBF_CMD_SERR_BIT  = 8;
    localparam logic        PCBF_CMD_RST       = 1'b0;

    // ==========================================================
    // Status half-word field positions (bit of the full word)
    localparam int          PCBF_STAT_TARGET_ABORT_SIGNALED_BIT = 27;
    localparam int          PCBF_STAT_SERR_BIT = 30;
    localparam int          PCBF_STAT_PERR_BIT = 31;
    // Fixed status: fast back-to-back target (23), timing 01b (26:25)
    localparam logic [15:0] PCBF_STAT_FIXED    = 16'h0280;

    // ==========================================================
    // Sticky status flags held by the flag module
    localparam int          PCBF_FLAG_NUM      = 3;
    localparam int          PCBF_FLAG_TARGET_ABORT_SIGNALED     = 0;
    localparam int          PCBF_FLAG_SERR     = 1;
    localparam int          PCBF_FLAG_PERR     = 2;
    localparam logic [2:0]  PCBF_FLAG_RST      = 3'h0;

    // ==========================================================
    // Fixed class and header fields
    localparam logic [7:0]  PCBF_CLASS_IFACE   = 8'h00;
    localparam logic [7:0]  PCBF_CLASS_SUB     = 8'h80;
    localparam logic [7:0]  PCBF_CLASS_BASE    = 8'h06;
    localparam logic [7:0]  PCBF_CACHE_LINE    = 8'h00;
    localparam logic [7:0]  PCBF_LAT_TIMER     = 8'h00;
    localparam logic [7:0]  PCBF_HDR_TYPE      = 8'h80;
    localparam logic [7:0]  PCBF_BIST          = 8'h00;
    localparam logic [31:0] PCBF_RDATA_RST     = 32'h0000_0000;

    // ==========================================================
    // State types
    typedef struct packed {
        logic [PCBF_FLAG_NUM-1:0] flags;
    } pcbf_flag_state_type;

    typedef struct packed {
        logic        mem_en;
        logic        par_en;
        logic        serr_en;
        logic        arb_meta;
        logic        arb_sync;
        logic        own_meta;
        logic        own_sync;
        logic        cfg_ack;
        logic [31:0] cfg_rdata;
        logic        mem_accept;
        logic        mem_ignore;
        logic        mem_abort;
        logic        io_claim;
        logic        perr_report;
        logic        serr_oe;
        logic        serr_out_n;
    } pcbf_top_state_type;

endpackage

// ### verilog/pcbf_status_flags.sv
// Sticky status flags, cleared by writing one, set wins over clear
`timescale 1ns/1ps

module pcbf_status_flags
    import pcbf_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic [PCBF_FLAG_NUM-1:0] flag_set,
    input  wire logic [PCBF_FLAG_NUM-1:0] flag_clr,
    output logic      [PCBF_FLAG_NUM-1:0] flags
);

    pcbf_flag_state_type st_r;
    pcbf_flag_state_type st_nxt;

    // ==========================================================
    // Per-flag next value
    genvar gi;
    generate
        for (gi = 0; gi < PCBF_FLAG_NUM; gi = gi + 1) begin : g_flag
            // An event in the clearing cycle keeps the flag set
            assign st_nxt.flags[gi] = flag_set[gi] |
                                      (st_r.flags[gi] & ~flag_clr[gi]);
        end
    endgenerate

    // ==========================================================
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r.flags <= PCBF_FLAG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags = st_r.flags;

endmodule // pcbf_status_flags

// ### verilog/pcbf_config_header.sv
// Configuration header of the local bus bridge function
//
// How it works
// - All command bits zero disconnects non-config accesses
// - Status reads plain; writing one clears a flag
// - I/O response bit reads zero, never claimed
// - Memory enable bit gates local bus window
// - Reset clears memory, parity and error enables
// - Master-related command bits read zero, unwritable
// - Parity enable bit decides acting on errors
// - Error enable bit allows driving error pin
// - Reserved command and status bits read zero
// - 66 MHz and user-feature bits read zero
// - Fast back-to-back target bit reads one
// - Master-only status flags always read zero
// - Select timing bits read fixed 01b
// - Target abort flag set on enabled memory access when bus unowned in arbitration mode
// - System error flag set even when disabled
// - Parity error flag set on detected error
// - Identification returns fixed vendor, device codes
// - Revision code and zero class interface
// - Subclass 80h and base class 06h
// - Header type 80h, cache and self-test zero
`timescale 1ns/1ps

module pcbf_config_header
    import pcbf_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [15:0] VENDOR_CODE   = 16'hA5C3,
    parameter logic [15:0] DEVICE_CODE   = 16'h5A17,
    parameter logic [7:0]  REVISION_CODE = 8'h01
)(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        cfg_req,
    input  wire logic        cfg_write,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic      [31:0] cfg_rdata,
    input  wire logic        mem_req,
    output logic             mem_accept,
    output logic             mem_ignore,
    output logic             mem_target_abort,
    output logic             io_claim,
    input  wire logic        lb_arb_mode_pin,
    input  wire logic        lb_owned_pin,
    input  wire logic        parity_err_det,
    output logic             parity_err_report,
    input  wire logic        serr_event,
    output logic             system_error_pin_n_out,
    output logic             system_error_pin_oe,
    output logic             memory_space_enable,
    output logic             parity_response_enable,
    output logic             system_error_output_enable
);

    // ==========================================================
    // State and combinational helpers
    pcbf_top_state_type       st_r;
    pcbf_top_state_type       st_nxt;
    logic [PCBF_FLAG_NUM-1:0] flag_set;
    logic [PCBF_FLAG_NUM-1:0] flag_clr;
    logic [PCBF_FLAG_NUM-1:0] flags;
    logic [15:0]              cmd_word;
    logic [15:0]              stat_word;
    logic [31:0]              rd_word;
    logic                     connected;
    logic                     cmdstat_wr;

    // ==========================================================
    // Sticky status flags
    pcbf_status_flags u_flags (
        .mclk     (mclk),
        .rst      (rst),
        .flag_set (flag_set),
        .flag_clr (flag_clr),
        .flags    (flags)
    );

    // ==========================================================
    // Command and status read images
    always_comb begin
        // Only the three enables are backed by storage
        cmd_word = 16'h0000;
        cmd_word[PCBF_CMD_MEM_BIT]  = st_r.mem_en;
        cmd_word[PCBF_CMD_PAR_BIT]  = st_r.par_en;
        cmd_word[PCBF_CMD_SERR_BIT] = st_r.serr_en;
        // Bits 10 to 15 stay zero
    end

    always_comb begin
        // Fixed capability pattern
        stat_word = PCBF_STAT_FIXED;
        // Master-only flags 24, 28, 29 never set
        stat_word[PCBF_STAT_TARGET_ABORT_SIGNALED_BIT-16] = flags[PCBF_FLAG_TARGET_ABORT_SIGNALED];
        stat_word[PCBF_STAT_SERR_BIT-16] = flags[PCBF_FLAG_SERR];
        stat_word[PCBF_STAT_PERR_BIT-16] = flags[PCBF_FLAG_PERR];
        // Bits 16 to 20 stay zero
    end

    // ==========================================================
    // Read decode
    always_comb begin
        rd_word = PCBF_RDATA_RST;
        if (cfg_addr == PCBF_ID_OFS) begin
            rd_word = {DEVICE_CODE, VENDOR_CODE};
        end else if (cfg_addr == PCBF_CMDSTAT_OFS) begin
            rd_word = {stat_word, cmd_word};
        end else if (cfg_addr == PCBF_REVCLASS_OFS) begin
            rd_word = {PCBF_CLASS_BASE, PCBF_CLASS_SUB,
                       PCBF_CLASS_IFACE, REVISION_CODE};
        end else if (cfg_addr == PCBF_HDRTYPE_OFS) begin
            rd_word = {PCBF_BIST, PCBF_HDR_TYPE,
                       PCBF_LAT_TIMER, PCBF_CACHE_LINE};
        end else begin
            rd_word = PCBF_RDATA_RST;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt    = st_r;
        flag_set  = '0;
        flag_clr  = '0;

        // Two-stage synchronisers for local bus pins
        st_nxt.arb_meta = lb_arb_mode_pin;
        st_nxt.arb_sync = st_r.arb_meta;
        st_nxt.own_meta = lb_owned_pin;
        st_nxt.own_sync = st_r.own_meta;

        // Logically detached while every command bit is zero
        connected = st_r.mem_en | st_r.par_en | st_r.serr_en;

        // Configuration access: always answered, one cycle later
        st_nxt.cfg_ack   = cfg_req;
        st_nxt.cfg_rdata = PCBF_RDATA_RST;
        if (cfg_req && !cfg_write) begin
            st_nxt.cfg_rdata = rd_word;
        end

        cmdstat_wr = cfg_req && cfg_write &&
                     (cfg_addr == PCBF_CMDSTAT_OFS);
        // Other writes are acknowledged and discarded
        if (cmdstat_wr) begin
            if (cfg_be[0]) begin
                st_nxt.mem_en = cfg_wdata[PCBF_CMD_MEM_BIT];
                st_nxt.par_en = cfg_wdata[PCBF_CMD_PAR_BIT];
            end
            if (cfg_be[1]) begin
                st_nxt.serr_en = cfg_wdata[PCBF_CMD_SERR_BIT];
            end
            if (cfg_be[3]) begin
                // Write one to clear
                flag_clr[PCBF_FLAG_TARGET_ABORT_SIGNALED] =
                    cfg_wdata[PCBF_STAT_TARGET_ABORT_SIGNALED_BIT];
                flag_clr[PCBF_FLAG_SERR] =
                    cfg_wdata[PCBF_STAT_SERR_BIT];
                flag_clr[PCBF_FLAG_PERR] =
                    cfg_wdata[PCBF_STAT_PERR_BIT];
            end
        end

        // Memory window access
        st_nxt.mem_accept = 1'b0;
        st_nxt.mem_ignore = 1'b0;
        st_nxt.mem_abort  = 1'b0;
        if (mem_req) begin
            if (!connected || !st_r.mem_en) begin
                st_nxt.mem_ignore = 1'b1;
            end else if (st_r.arb_sync && !st_r.own_sync) begin
                // Arbitration mode and bus not held by host
                st_nxt.mem_abort = 1'b1;
                flag_set[PCBF_FLAG_TARGET_ABORT_SIGNALED] = 1'b1;
            end else begin
                st_nxt.mem_accept = 1'b1;
            end
        end

        // I/O space is never claimed
        st_nxt.io_claim = 1'b0;

        // Parity errors always flagged, acted on only when enabled
        flag_set[PCBF_FLAG_PERR] = parity_err_det;
        st_nxt.perr_report = parity_err_det & st_r.par_en;

        // System error flagged even with the pin disabled
        flag_set[PCBF_FLAG_SERR] = serr_event;
        st_nxt.serr_oe    = serr_event & st_r.serr_en;
        st_nxt.serr_out_n = ~(serr_event & st_r.serr_en);
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r.mem_en      <= PCBF_CMD_RST;
            st_r.par_en      <= PCBF_CMD_RST;
            st_r.serr_en     <= PCBF_CMD_RST;
            st_r.arb_meta    <= 1'b0;
            st_r.arb_sync    <= 1'b0;
            st_r.own_meta    <= 1'b0;
            st_r.own_sync    <= 1'b0;
            st_r.cfg_ack     <= 1'b0;
            st_r.cfg_rdata   <= PCBF_RDATA_RST;
            st_r.mem_accept  <= 1'b0;
            st_r.mem_ignore  <= 1'b0;
            st_r.mem_abort   <= 1'b0;
            st_r.io_claim    <= 1'b0;
            st_r.perr_report <= 1'b0;
            st_r.serr_oe     <= 1'b0;
            st_r.serr_out_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign cfg_ack                    = st_r.cfg_ack;
    assign cfg_rdata                  = st_r.cfg_rdata;
    assign mem_accept                 = st_r.mem_accept;
    assign mem_ignore                 = st_r.mem_ignore;
    assign mem_target_abort           = st_r.mem_abort;
    assign io_claim                   = st_r.io_claim;
    assign parity_err_report          = st_r.perr_report;
    assign system_error_pin_n_out     = st_r.serr_out_n;
    assign system_error_pin_oe        = st_r.serr_oe;
    assign memory_space_enable        = st_r.mem_en;
    assign parity_response_enable     = st_r.par_en;
    assign system_error_output_enable = st_r.serr_en;

endmodule // pcbf_config_header

// ### bench/pcbf_config_header_checker.sv
// Port assertions for the bridge function configuration header
`timescale 1ns/1ps

module pcbf_config_header_checker
    import pcbf_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        cfg_req,
    input wire logic        cfg_write,
    input wire logic [11:0] cfg_addr,
    input wire logic        cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic        mem_req,
    input wire logic        mem_accept,
    input wire logic        mem_ignore,
    input wire logic        mem_target_abort,
    input wire logic        io_claim,
    input wire logic        parity_err_det,
    input wire logic        parity_err_report,
    input wire logic        serr_event,
    input wire logic        system_error_pin_n_out,
    input wire logic        system_error_pin_oe,
    input wire logic        memory_space_enable,
    input wire logic        parity_response_enable,
    input wire logic        system_error_output_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Register access
    chk_ack_follows_req: assert property (cfg_req |=> cfg_ack)
        else $error("config access not acknowledged");
    chk_cmd_fixed_zero: assert property (
        cfg_req && !cfg_write && cfg_addr == PCBF_CMDSTAT_OFS
        |=> (cfg_rdata[15:0] & 16'hFEBD) == 16'h0000)
        else $error("fixed command bits not zero");
    chk_stat_fixed: assert property (
        cfg_req && !cfg_write && cfg_addr == PCBF_CMDSTAT_OFS
        |=> (cfg_rdata[31:16] & 16'h37FF) == 16'h0280)
        else $error("fixed status bits wrong");
    chk_reset_clears_en: assert property ($past(rst) |->
        !memory_space_enable && !parity_response_enable
        && !system_error_output_enable)
        else $error("enables not cleared by reset");

    // ==========================================================
    // Memory window and error pins
    chk_io_never: assert property (!io_claim)
        else $error("io space claimed");
    chk_mem_gated_off: assert property (
        mem_req && !memory_space_enable
        |=> mem_ignore && !mem_accept && !mem_target_abort)
        else $error("memory access not ignored");
    chk_mem_accept_cause: assert property (mem_accept |->
        $past(mem_req) && $past(memory_space_enable))
        else $error("memory accept without enable");
    chk_mem_one_answer: assert property (
        mem_req |=> $onehot({mem_accept, mem_ignore, mem_target_abort}))
        else $error("memory access answer not single");
    chk_parity_gate: assert property (
        parity_err_det |=> parity_err_report == $past(parity_response_enable))
        else $error("parity report not gated");
    chk_serr_gate: assert property (
        serr_event && system_error_output_enable
        |=> system_error_pin_oe && !system_error_pin_n_out)
        else $error("error pin not driven");
endmodule // pcbf_config_header_checker

bind pcbf_config_header pcbf_config_header_checker u_chk (
    .mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .mem_req(mem_req), .mem_accept(mem_accept), .mem_ignore(mem_ignore),
    .mem_target_abort(mem_target_abort), .io_claim(io_claim),
    .parity_err_det(parity_err_det), .parity_err_report(parity_err_report),
    .serr_event(serr_event), .system_error_pin_n_out(system_error_pin_n_out),
    .system_error_pin_oe(system_error_pin_oe),
    .memory_space_enable(memory_space_enable),
    .parity_response_enable(parity_response_enable),
    .system_error_output_enable(system_error_output_enable));

// ### bench/pcbf_host_model.sv
// Host model issuing configuration and memory accesses
`timescale 1ns/1ps

module pcbf_host_model (
    input  wire logic        mclk,
    output logic             cfg_req,
    output logic             cfg_write,
    output logic      [11:0] cfg_addr,
    output logic      [3:0]  cfg_be,
    output logic      [31:0] cfg_wdata,
    output logic             mem_req
);
    initial begin
        {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata, mem_req} = '0;
    end

    // One request held across its taking edge; released lines invert
    task automatic cfg_op(input logic w, input logic [11:0] a,
                          input logic [3:0] be, input logic [31:0] d);
        @(negedge mclk);
        {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata} =
            {1'b1, w, a, be, d};
        @(negedge mclk);
        {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata} =
            {1'b0, ~w, ~a, ~be, ~d};
    endtask

    // One-cycle memory window request, whatever the local bus pins
    task automatic mem_op;
        @(negedge mclk);
        mem_req = 1'b1;
        @(negedge mclk);
        mem_req = 1'b0;
    endtask
endmodule // pcbf_host_model

// ### bench/pcbf_config_header_test.sv
// Self-checking testbench of the bridge function configuration header
`timescale 1ns/1ps

module pcbf_config_header_test
    import pcbf_pkg::*;
;
    localparam logic [15:0] VEN = 16'h1D2E; // Arbitrary value
    localparam logic [15:0] DEV = 16'h0F4B; // Arbitrary value
    localparam logic [7:0]  REV = 8'h3C;    // Arbitrary value
    localparam logic [11:0] CS  = PCBF_CMDSTAT_OFS;

    logic        mclk, rst, cfg_req, cfg_write, cfg_ack, mem_req, io_claim;
    logic        mem_accept, mem_ignore, mem_target_abort, serr_event;
    logic        lb_arb_mode_pin, lb_owned_pin, parity_err_det, pe_rep;
    logic        serr_n, serr_oe, mem_en, par_en, serr_en;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, d, exp_w;
    logic [2:0]  exp_m;
    logic [31:0] cfg_q[$];
    logic [2:0]  mem_q[$];
    integer      fails = 0, checks_done = 0, seed = 32'h0bb3c944;

    pcbf_host_model u_host (.mclk(mclk), .cfg_req(cfg_req),
        .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .mem_req(mem_req));

    pcbf_config_header #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV),
        .REVISION_CODE(REV)) DUT (.mclk(mclk), .rst(rst), .cfg_req(cfg_req),
        .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .mem_req(mem_req), .mem_accept(mem_accept), .mem_ignore(mem_ignore),
        .mem_target_abort(mem_target_abort), .io_claim(io_claim),
        .lb_arb_mode_pin(lb_arb_mode_pin), .lb_owned_pin(lb_owned_pin),
        .parity_err_det(parity_err_det), .parity_err_report(pe_rep),
        .serr_event(serr_event), .system_error_pin_n_out(serr_n),
        .system_error_pin_oe(serr_oe), .memory_space_enable(mem_en),
        .parity_response_enable(par_en),
        .system_error_output_enable(serr_en));

    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        cfg_q.push_back(e);
        u_host.cfg_op(1'b0, a, 4'h0, 32'h0);
    endtask
    // Writes answer with zero read data
    task automatic wr(input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] v);
        cfg_q.push_back(32'h0);
        u_host.cfg_op(1'b1, a, be, v);
    endtask
    task automatic ro_chk(input logic [11:0] a, input logic [31:0] e);
        wr(a, 4'hF, 32'hFFFF_FFFF);
        rd(a, e);
    endtask
    task automatic mem(input logic [2:0] e);
        mem_q.push_back(e);
        u_host.mem_op();
    endtask
    // Pin change, then time for the two-flop synchroniser
    task automatic pins(input logic arb, input logic own);
        @(negedge mclk);
        {lb_arb_mode_pin, lb_owned_pin} = {arb, own};
        repeat (3) @(negedge mclk);
    endtask
    // Error pulse; pins and enables checked while the answer stands
    task automatic pulse(input logic [5:0] e);
        @(negedge mclk);
        {parity_err_det, serr_event} = 2'h3;
        @(negedge mclk);
        check(32'({pe_rep, serr_oe, serr_n, mem_en, par_en, serr_en}),
              32'(e));
        {parity_err_det, serr_event} = 2'h0;
    endtask

    // ==========================================================
    // Result monitor: oldest note against each answer
    always @(negedge mclk) begin
        if (cfg_ack === 1'b1) begin
            exp_w = (cfg_q.size() > 0) ? cfg_q.pop_front() : ~cfg_rdata;
            check(cfg_rdata, exp_w);
        end
        if ((mem_accept | mem_ignore | mem_target_abort) !== 1'b0) begin
            exp_m = (mem_q.size() > 0) ? mem_q.pop_front() : 3'h0;
            check(32'({mem_accept, mem_ignore, mem_target_abort}),
                  32'(exp_m));
        end
    end

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        tally_and_finish;
    end

    // ==========================================================
    // Main sequence
    initial begin
        {rst, lb_arb_mode_pin, lb_owned_pin} = 3'h4;
        {parity_err_det, serr_event} = 2'h0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        rd(PCBF_ID_OFS, {DEV, VEN});
        rd(CS, 32'h0280_0000);
        rd(12'h1F0, 32'h0);
        mem(3'h2);
        ro_chk(PCBF_ID_OFS, {DEV, VEN});
        ro_chk(PCBF_REVCLASS_OFS, {16'h0680, 8'h00, REV});
        ro_chk(PCBF_HDRTYPE_OFS, 32'h0080_0000);
        $display("test fixed_fields done");
        repeat (4) begin
            d = $random(seed);
            wr(CS, 4'h3, d);
            rd(CS, {16'h0280, d[15:0] & 16'h0142});
        end
        wr(CS, 4'hF, 32'h0);
        wr(CS, 4'h1, 32'hFFFF_FFFF);
        rd(CS, 32'h0280_0042);
        wr(CS, 4'h2, 32'hFFFF_FFFF);
        rd(CS, 32'h0280_0142);
        $display("test command_bits done");
        mem(3'h4);
        pins(1'b1, 1'b0);
        mem(3'h1);
        rd(CS, 32'h0A80_0142);
        pins(1'b1, 1'b1);
        mem(3'h4);
        wr(CS, 4'h8, 32'h0800_0000);
        rd(CS, 32'h0280_0142);
        $display("test memory_window done");
        pulse(6'h37);
        rd(CS, 32'hC280_0142);
        wr(CS, 4'h8, 32'h4000_0000);
        rd(CS, 32'h8280_0142);
        wr(CS, 4'h3, 32'h0);
        pulse(6'h08);
        rd(CS, 32'hC280_0000);
        mem(3'h2);
        wr(CS, 4'hF, 32'hFFFF_0000);
        rd(CS, 32'h0280_0000);
        $display("test error_flags done");
        wr(CS, 4'h3, 32'h0000_0142);
        rd(CS, 32'h0280_0142);
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        rd(CS, 32'h0280_0000);
        mem(3'h2);
        $display("test mid_reset done");
        repeat (3) @(negedge mclk);
        check(32'(cfg_q.size() + mem_q.size()), 32'h0);
        tally_and_finish;
    end
endmodule // pcbf_config_header_test
